// ==== rtl/mxb_pkg.sv ====
// constants, types and register map of the muxed external bus interface
package mxb_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFF_CFG0 = 8'h00; // config_byte_zero
	localparam logic [7:0] OFF_CFG1 = 8'h04; // config_byte_one
	localparam logic [7:0] OFF_WSEL = 8'h08; // window selection register
	localparam logic [7:0] OFF_GPIO = 8'h0C; // port 3/4 output value and enable
	localparam logic [7:0] OFF_STAT = 8'h10; // read-only status
	// field positions
	localparam int CFG0_HBE_BIT = 2; // 1 = high-byte enable, 0 = high-byte write
	localparam int CFG0_W16_BIT = 1; // first width bit
	localparam int CFG1_W8_BIT = 2; // second width bit
	localparam int WSEL_HOLD_BIT = 7; // takeover protocol enable
	localparam int STAT_SRC_BIT = 0; // latched memory source, 1 = internal
	localparam int STAT_W16_BIT = 1; // present width is 16 bits
	localparam int STAT_HOLD_BIT = 2; // bus granted away
	localparam int STAT_PENDING_CYCLE_REQUEST_N_BIT = 3; // pending cycle request driven
	localparam int STAT_BUSY_BIT = 4; // external cycle running
	localparam int STAT_PIN_LSB = 16; // sampled shared lines
	// reset values
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] CFG1_RST = 8'h04; // 8-bit bus after reset
	localparam logic [7:0] WSEL_RST = 8'h00;
	localparam logic [31:0] GPIO_RST = 32'h0000_0000;
	// timing counts in sys_clk cycles
	localparam logic [1:0] DATA_CYC = 2'h2; // length of the data phase
	// bus controller states
	typedef enum logic [2:0] {
		MXB_IDLE,
		MXB_ADDR,
		MXB_DATA,
		MXB_GAP,
		MXB_HOLD
	} mxb_state_t;
	// one memory request from the core side
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic write;
		logic word;
		logic prog_space; // special-purpose or program partition
	} mxb_req_t;
	// external bus pin outputs
	typedef struct packed {
		logic [15:0] ad_out;
		logic [15:0] ad_oe;
		logic addr_valid_n;
		logic addr_strobe;
		logic high_byte_n;
		logic write_n;
		logic read_n;
	} mxb_pins_t;
endpackage

// ==== rtl/mxb_bus_if.sv ====
// muxed external bus controller with apb configuration registers
// Notes on behaviour
// - sixteen lines carry address then data
// - address valid low for whole external cycle
// - address strobe pulses at cycle start only
// - config zero bit 2 picks upper-byte function
// - high-byte enable with lowest bit selects bytes
// - request out while held and cycle pending
// - request with/after grant, until hold removed
// - request works only with takeover enabled
// - two config bits plus pin set width
// - memory source caught once at reset release
// - latched source routes program partition accesses
// - external program access blocks port gpio use
// - clock output is half rate, even duty
// - inputs sampled, reset level sensitive
// - grant output low while bus released
// - window select bit 7 enables takeover
module mxb_bus_if (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core request port
	input wire logic req_valid,
	input wire mxb_pkg::mxb_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	output logic rsp_internal,
	// external pins
	input wire logic [15:0] ad_in,
	output mxb_pkg::mxb_pins_t pins,
	input wire logic hold_n,
	output logic takeover_grant_n,
	output logic pending_cycle_request_n,
	input wire logic width_select_pin,
	input wire logic memory_source_select_n,
	output logic system_clock_output
);
	mxb_pkg::mxb_state_t st_ff; // bus controller state
	mxb_pkg::mxb_req_t cur_ff; // request being served
	logic [1:0] cnt_ff; // data phase cycle counter
	logic hi_ff; // second byte of a split word
	logic bus16_ff; // width frozen for the running request
	logic [15:0] rdata_ff; // assembled read data
	logic rsp_ff; // answer pulse
	logic rsp_int_ff; // answer served internally
	logic pending_cycle_request_n_ff; // pending cycle request level
	logic clk_ff; // clock output divider
	logic src_int_ff; // latched source, 1 = internal
	logic captured_ff; // source already latched
	logic [7:0] cfg0_ff;
	logic [7:0] cfg1_ff;
	logic [7:0] wsel_ff;
	logic [31:0] gpio_ff; // [15:0] value, [31:16] enable
	logic hold_s_ff; // sampled hold request
	logic width_s_ff; // sampled width pin
	logic [15:0] ad_s_ff; // sampled shared lines for status
	logic [31:0] prdata_ff;
	logic bus16; // width in force now
	logic ext_route; // request must go out on the bus
	logic take_hold; // takeover requested and enabled
	logic accept; // request taken this cycle
	logic last_data; // final data phase cycle
	logic split_more; // 8-bit bus word needs high byte
	logic hbe_mode;
	logic apb_hit; // address decodes to a register
	logic [15:0] wlane; // write data lane placement

	// inputs are sampled; only rst acts on level
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hold_s_ff <= 1'b1;
			width_s_ff <= 1'b0;
			ad_s_ff <= 16'h0000;
		end else if (ce) begin
			hold_s_ff <= hold_n;
			width_s_ff <= width_select_pin;
			ad_s_ff <= ad_in;
		end
	end

	// memory source caught on the first enabled edge after reset release
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			captured_ff <= 1'b0;
			src_int_ff <= 1'b0;
		end else if (ce && !captured_ff) begin
			captured_ff <= 1'b1;
			src_int_ff <= memory_source_select_n;
		end
	end

	// clock output: toggles every enabled oscillator edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clk_ff <= 1'b0;
		end else if (ce) begin
			clk_ff <= ~clk_ff;
		end
	end
	assign system_clock_output = clk_ff;

	// width decode; both bits clear is undefined, treated as 8-bit
	always_comb begin
		unique case ({cfg0_ff[mxb_pkg::CFG0_W16_BIT], cfg1_ff[mxb_pkg::CFG1_W8_BIT]})
			2'b10: bus16 = 1'b1;
			2'b11: bus16 = width_s_ff;
			default: bus16 = 1'b0;
		endcase
	end

	// program partition goes inside only when the source latched high
	assign ext_route = !(req.prog_space && src_int_ff);
	assign take_hold = !hold_s_ff && wsel_ff[mxb_pkg::WSEL_HOLD_BIT];
	assign hbe_mode = cfg0_ff[mxb_pkg::CFG0_HBE_BIT];
	// no request before the source is known, so routing is never guessed
	assign req_ready = ce && captured_ff &&
		((st_ff == mxb_pkg::MXB_IDLE && !take_hold) ||
		(st_ff == mxb_pkg::MXB_HOLD && !ext_route));
	assign accept = req_valid && req_ready;
	assign last_data = (st_ff == mxb_pkg::MXB_DATA) && (cnt_ff == mxb_pkg::DATA_CYC - 2'h1);
	assign split_more = !bus16_ff && cur_ff.word && !hi_ff;

	// bus controller sequencing
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_ff <= mxb_pkg::MXB_IDLE;
			cnt_ff <= 2'h0;
			hi_ff <= 1'b0;
		end else if (ce) begin
			unique case (st_ff)
				mxb_pkg::MXB_IDLE: begin
					if (take_hold) begin
						st_ff <= mxb_pkg::MXB_HOLD;
					end else if (accept && ext_route) begin
						st_ff <= mxb_pkg::MXB_ADDR;
						hi_ff <= 1'b0;
					end
				end
				mxb_pkg::MXB_ADDR: begin
					st_ff <= mxb_pkg::MXB_DATA;
					cnt_ff <= 2'h0;
				end
				mxb_pkg::MXB_DATA: begin
					if (last_data) begin
						// end of cycle: address valid rises next
						st_ff <= split_more ? mxb_pkg::MXB_GAP : mxb_pkg::MXB_IDLE;
					end else begin
						cnt_ff <= cnt_ff + 2'h1;
					end
				end
				mxb_pkg::MXB_GAP: begin
					// separates the two byte cycles of a word on an 8-bit bus
					st_ff <= mxb_pkg::MXB_ADDR;
					hi_ff <= 1'b1;
				end
				mxb_pkg::MXB_HOLD: begin
					if (hold_s_ff) begin
						st_ff <= mxb_pkg::MXB_IDLE;
					end
				end
			endcase
		end
	end

	// capture of the request and its width
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_ff <= '0;
			bus16_ff <= 1'b0;
		end else if (ce && accept && ext_route && st_ff == mxb_pkg::MXB_IDLE) begin
			cur_ff <= req;
			cur_ff.addr[0] <= req.addr[0] && !req.word; // words are aligned
			bus16_ff <= bus16;
		end
	end

	// read data assembly and answer pulse
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
			rsp_ff <= 1'b0;
			rsp_int_ff <= 1'b0;
		end else if (ce) begin
			rsp_ff <= 1'b0;
			if (accept && !ext_route) begin
				// internal memory lives outside this block; answer at once
				rsp_ff <= 1'b1;
				rsp_int_ff <= 1'b1;
				rdata_ff <= 16'h0000;
			end else if (last_data) begin
				rsp_ff <= !split_more;
				rsp_int_ff <= 1'b0;
				if (!cur_ff.write) begin
					if (bus16_ff && cur_ff.word) begin
						rdata_ff <= ad_in;
					end else if (bus16_ff) begin
						rdata_ff <= {8'h00, cur_ff.addr[0] ? ad_in[15:8] : ad_in[7:0]};
					end else if (hi_ff) begin
						rdata_ff[15:8] <= ad_in[7:0];
					end else begin
						rdata_ff <= {8'h00, ad_in[7:0]};
					end
				end
			end
		end
	end
	assign rsp_valid = rsp_ff;
	assign rsp_rdata = rdata_ff;
	assign rsp_internal = rsp_int_ff;

	// pending cycle request: only inside a granted hold, kept until hold ends
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pending_cycle_request_n_ff <= 1'b0;
		end else if (ce) begin
			if (st_ff != mxb_pkg::MXB_HOLD || hold_s_ff) begin
				pending_cycle_request_n_ff <= 1'b0;
			end else if (req_valid && ext_route && wsel_ff[mxb_pkg::WSEL_HOLD_BIT]) begin
				pending_cycle_request_n_ff <= 1'b1;
			end
		end
	end
	assign pending_cycle_request_n = !pending_cycle_request_n_ff;
	assign takeover_grant_n = !(st_ff == mxb_pkg::MXB_HOLD);

	// write data lanes: byte accesses mirrored so either lane is valid; a split word's high byte goes on the low lane only
	always_comb begin
		if (bus16_ff && cur_ff.word) begin
			wlane = cur_ff.wdata;
		end else if (!bus16_ff && hi_ff) begin
			wlane = {8'h00, cur_ff.wdata[15:8]};
		end else begin
			wlane = {cur_ff.wdata[7:0], cur_ff.wdata[7:0]};
		end
	end

	// pin drive per state
	always_comb begin
		pins.addr_valid_n = 1'b1;
		pins.addr_strobe = 1'b0;
		pins.high_byte_n = 1'b1;
		pins.write_n = 1'b1;
		pins.read_n = 1'b1;
		pins.ad_out = 16'h0000;
		pins.ad_oe = 16'h0000;
		unique case (st_ff)
			mxb_pkg::MXB_ADDR: begin
				pins.addr_valid_n = 1'b0;
				pins.addr_strobe = 1'b1;
				pins.ad_out = {cur_ff.addr[15:1], cur_ff.addr[0] | hi_ff};
				pins.ad_oe = 16'hFFFF;
				pins.high_byte_n = !(hbe_mode && bus16_ff && (cur_ff.word || cur_ff.addr[0]));
			end
			mxb_pkg::MXB_DATA: begin
				pins.addr_valid_n = 1'b0;
				pins.read_n = cur_ff.write;
				pins.ad_out = wlane;
				// reads release the lines so memory can drive them
				pins.ad_oe = cur_ff.write ? (bus16_ff ? 16'hFFFF : 16'h00FF) : 16'h0000;
				if (hbe_mode) begin
					pins.high_byte_n = !(bus16_ff && (cur_ff.word || cur_ff.addr[0]));
					pins.write_n = !cur_ff.write;
				end else begin
					pins.high_byte_n = !(cur_ff.write && bus16_ff &&
						(cur_ff.word || cur_ff.addr[0]));
					pins.write_n = !(cur_ff.write &&
						(!bus16_ff || cur_ff.word || !cur_ff.addr[0]));
				end
			end
			mxb_pkg::MXB_IDLE: begin
				// ports 3/4 serve as gpio only when program access is internal
				if (captured_ff && src_int_ff) begin
					pins.ad_out = gpio_ff[15:0];
					pins.ad_oe = gpio_ff[31:16];
				end
			end
			default: begin
				// gap and hold leave the lines floating
			end
		endcase
	end

	// apb decode and register writes
	always_comb begin
		unique case (paddr)
			mxb_pkg::OFF_CFG0, mxb_pkg::OFF_CFG1, mxb_pkg::OFF_WSEL,
			mxb_pkg::OFF_GPIO, mxb_pkg::OFF_STAT: apb_hit = 1'b1;
			default: apb_hit = 1'b0;
		endcase
	end
	assign pready = ce; // zero wait states unless frozen
	assign pslverr = psel && penable && !apb_hit;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg0_ff <= mxb_pkg::CFG0_RST;
			cfg1_ff <= mxb_pkg::CFG1_RST;
			wsel_ff <= mxb_pkg::WSEL_RST;
			gpio_ff <= mxb_pkg::GPIO_RST;
		end else if (ce && psel && penable && pwrite) begin
			// changing width mid-cycle is safe: each request froze its own
			unique case (paddr)
				mxb_pkg::OFF_CFG0: cfg0_ff <= pwdata[7:0];
				mxb_pkg::OFF_CFG1: cfg1_ff <= pwdata[7:0];
				mxb_pkg::OFF_WSEL: wsel_ff <= pwdata[7:0];
				mxb_pkg::OFF_GPIO: gpio_ff <= pwdata;
				default: begin
					// read-only or unmapped: ignored
				end
			endcase
		end
	end

	// read data prepared in the setup cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_ff <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			prdata_ff <= 32'h0000_0000;
			unique case (paddr)
				mxb_pkg::OFF_CFG0: prdata_ff[7:0] <= cfg0_ff;
				mxb_pkg::OFF_CFG1: prdata_ff[7:0] <= cfg1_ff;
				mxb_pkg::OFF_WSEL: prdata_ff[7:0] <= wsel_ff;
				mxb_pkg::OFF_GPIO: prdata_ff <= gpio_ff;
				mxb_pkg::OFF_STAT: begin
					prdata_ff[mxb_pkg::STAT_SRC_BIT] <= src_int_ff;
					prdata_ff[mxb_pkg::STAT_W16_BIT] <= bus16;
					prdata_ff[mxb_pkg::STAT_HOLD_BIT] <= (st_ff == mxb_pkg::MXB_HOLD);
					prdata_ff[mxb_pkg::STAT_PENDING_CYCLE_REQUEST_N_BIT] <= pending_cycle_request_n_ff;
					prdata_ff[mxb_pkg::STAT_BUSY_BIT] <= (st_ff != mxb_pkg::MXB_IDLE &&
						st_ff != mxb_pkg::MXB_HOLD);
					prdata_ff[mxb_pkg::STAT_PIN_LSB +: 16] <= ad_s_ff;
				end
				default: begin
					// unmapped reads as zero
				end
			endcase
		end
	end
	assign prdata = prdata_ff;

	// checks on the bus behaviour
	property p_strobe_pulse;
		@(posedge sys_clk) disable iff (rst || !ce)
		pins.addr_strobe |=> !pins.addr_strobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe held");

	property p_valid_span;
		@(posedge sys_clk) disable iff (rst || !ce)
		$rose(pins.addr_strobe) |-> (!pins.addr_valid_n)[*3] ##1 pins.addr_valid_n;
	endproperty
	a_valid_span: assert property (p_valid_span) else $error("addr valid span wrong");

	property p_read_release;
		@(posedge sys_clk) disable iff (rst)
		!pins.read_n |-> (pins.ad_oe == 16'h0000);
	endproperty
	a_read_release: assert property (p_read_release) else $error("lines driven in read");

	property p_low_byte_only;
		@(posedge sys_clk) disable iff (rst)
		(!pins.read_n && hbe_mode && bus16_ff && !cur_ff.word && !cur_ff.addr[0])
			|-> pins.high_byte_n;
	endproperty
	a_low_byte_only: assert property (p_low_byte_only) else $error("bhe on low byte");

	property p_req_after_grant;
		@(posedge sys_clk) disable iff (rst)
		!pending_cycle_request_n |-> !takeover_grant_n;
	endproperty
	a_req_after_grant: assert property (p_req_after_grant) else $error("request w/o grant");

	property p_req_kept;
		@(posedge sys_clk) disable iff (rst || !ce)
		$rose(pending_cycle_request_n) |-> $past(hold_s_ff);
	endproperty
	a_req_kept: assert property (p_req_kept) else $error("request dropped early");

	property p_req_enabled;
		@(posedge sys_clk) disable iff (rst)
		$fell(pending_cycle_request_n) |-> $past(wsel_ff[mxb_pkg::WSEL_HOLD_BIT]);
	endproperty
	a_req_enabled: assert property (p_req_enabled) else $error("request while disabled");

	property p_clk_half;
		@(posedge sys_clk) disable iff (rst)
		ce |=> (system_clock_output != $past(system_clock_output));
	endproperty
	a_clk_half: assert property (p_clk_half) else $error("clock output stuck");

	property p_src_stable;
		@(posedge sys_clk) disable iff (rst)
		(captured_ff && $past(captured_ff)) |-> $stable(src_int_ff);
	endproperty
	a_src_stable: assert property (p_src_stable) else $error("source relatched");

	property p_no_gpio_ext;
		@(posedge sys_clk) disable iff (rst)
		(st_ff == mxb_pkg::MXB_IDLE && !src_int_ff) |-> (pins.ad_oe == 16'h0000);
	endproperty
	a_no_gpio_ext: assert property (p_no_gpio_ext) else $error("gpio in external mode");

	c_split_word: cover property (@(posedge sys_clk) disable iff (rst)
		st_ff == mxb_pkg::MXB_GAP);
	c_pending_cycle_request_n: cover property (@(posedge sys_clk) disable iff (rst) $fell(pending_cycle_request_n));
	c_internal: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid && rsp_internal);
endmodule

// ==== tb/mxb_ext_mem.sv ====
// external byte memory with an address latch, facing the muxed bus
module mxb_ext_mem (
	input wire logic sys_clk,
	input wire logic [15:0] bus_lvl,
	input wire mxb_pkg::mxb_pins_t pins,
	input wire logic bus16,
	input wire logic hbe_mode,
	output logic [15:0] mem_dq,
	output logic clash
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256]; // byte store, aliased every 256 bytes
	logic [7:0] alat; // address caught by the strobe
	logic [15:0] junk = 16'h5AC3; // changes every cycle while released
	logic rd_on; // memory drives the lines
	logic lo_wr; // low lane write
	logic hi_wr; // high lane write
	// chip select comes from address valid, never from the strobe
	assign rd_on = !pins.addr_valid_n && !pins.read_n;
	assign mem_dq = rd_on ? {mem[alat | 8'h01], mem[bus16 ? alat & 8'hFE : alat]} : junk;
	// both parties driving at once is a fault of the device
	assign clash = rd_on && (pins.ad_oe !== 16'h0000);
	// odd bytes on a 16-bit bus never touch the low lane
	assign lo_wr = !pins.write_n && (!bus16 || !alat[0]);
	assign hi_wr = bus16 && !pins.high_byte_n && (!hbe_mode || !pins.write_n);
	initial begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	// latch, store and scramble released lines
	always @(posedge sys_clk) begin
		if (pins.addr_strobe)
			alat <= bus_lvl[7:0];
		if (lo_wr && !pins.addr_valid_n)
			mem[alat] <= bus_lvl[7:0];
		if (hi_wr && !pins.addr_valid_n)
			mem[alat | 8'h01] <= bus_lvl[15:8];
		junk <= rd_on ? ~mem_dq : ~junk;
	end
endmodule

// ==== tb/muxed_external_bus_interface_test.sv ====
// self-checking bench for the muxed external bus interface
module muxed_external_bus_interface_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'h0; // 200 MHz
	logic rst = 1'h1;
	logic ce = 1'h1; // clock enable, pulled low once to freeze the block
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, req_ready, rsp_valid, rsp_internal, clash;
	logic req_valid = 1'h0;
	mxb_pkg::mxb_req_t req = '0;
	logic [15:0] rsp_rdata, mem_dq, bus_lvl;
	mxb_pkg::mxb_pins_t pins;
	logic hold_n = 1'h1; // other master's takeover request
	logic wpin = 1'h0; // width select pin
	logic src_n = 1'h0; // memory source select
	logic bus16 = 1'h0;
	logic hbe = 1'h0;
	logic src_int = 1'h0; // source latched at the last reset
	logic grant_n, pending_cycle_request_n_n, clk_out;
	int err_count = 0;
	int checks = 0;
	int mdl [256]; // reference byte memory
	always #2.5 sys_clk = ~sys_clk;
	// wire level: the device where enabled, else the memory
	assign bus_lvl = (pins.ad_oe & pins.ad_out) | (~pins.ad_oe & mem_dq);
	mxb_bus_if dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_internal(rsp_internal), .ad_in(bus_lvl), .pins(pins), .hold_n(hold_n),
		.takeover_grant_n(grant_n), .pending_cycle_request_n(pending_cycle_request_n_n),
		.width_select_pin(wpin), .memory_source_select_n(src_n),
		.system_clock_output(clk_out));
	mxb_ext_mem mem_u (.sys_clk(sys_clk), .bus_lvl(bus_lvl), .pins(pins), .bus16(bus16),
		.hbe_mode(hbe), .mem_dq(mem_dq), .clash(clash));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic give_up(input string what);
		chk(what, 32'h1, 32'h0);
		print_verdict();
	endtask
	// one apb transfer; result left in rd and err
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50)
			give_up("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// reset with a chosen source level, which then flips
	task automatic do_reset(input logic s);
		@(posedge sys_clk);
		rst <= 1'h1;
		src_n <= s;
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (2) @(posedge sys_clk);
		src_n <= ~s;
	endtask
	// one core request, checked against the reference memory
	task automatic xfer(input logic w, input logic wd, input logic pg, input logic [15:0] a,
		input logic [15:0] d);
		int n, ns;
		logic intl;
		logic [7:0] lo;
		logic [1:0] hb;
		n = 0;
		ns = 0;
		hb = 2'h0;
		intl = pg && src_int;
		lo = wd ? a[7:0] & 8'hFE : a[7:0];
		@(posedge sys_clk);
		req_valid <= 1'h1;
		req <= '{a, d, w, wd, pg};
		do begin
			@(posedge sys_clk);
			n++;
		end while (req_ready !== 1'h1 && n < 200);
		if (n >= 200)
			give_up("req_ready");
		req_valid <= 1'h0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (pins.addr_strobe === 1'h1) begin
				ns++;
				hb = {pins.high_byte_n, bus_lvl[0]};
			end
		end while (rsp_valid !== 1'h1 && n < 20);
		if (n >= 20)
			give_up("rsp_valid");
		chk("latency", intl ? 1 : (bus16 || !wd) ? 4 : 8, n);
		chk("strobes", intl ? 0 : (bus16 || !wd) ? 1 : 2, ns);
		chk("internal", intl, rsp_internal);
		if (bus16 && !intl)
			chk("upper pin", {!hbe || (!wd && !a[0]), !wd && a[0]}, hb);
		if (intl)
			chk("rdata", 32'h0, rsp_rdata);
		else if (w) begin
			mdl[lo] = d[7:0];
			if (wd)
				mdl[lo | 8'h01] = d[15:8];
		end else if (wd)
			chk("rdata", {mdl[lo | 8'h01][7:0], mdl[lo][7:0]}, rsp_rdata);
		else
			chk("rdata", mdl[lo][7:0], rsp_rdata[7:0]);
	endtask
	// the memory must never fight the device
	always @(posedge sys_clk) begin
		if (clash === 1'h1)
			chk("line clash", 32'h0, 32'h1);
	end
	initial begin
		int i, m;
		logic [31:0] r;
		logic [16:0] q [$];
		logic [7:0] mc0 [5];
		logic [7:0] mc1 [5];
		logic c0, c1;
		mc0 = '{8'h00, 8'h06, 8'h02, 8'h06, 8'h06};
		mc1 = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h04};
		void'($urandom(32'h503D));
		do_reset(1'h0);
		chk("idle pins", 8'h5F, {pins.addr_valid_n, pins.addr_strobe, pins.high_byte_n,
			pins.write_n, pins.read_n, grant_n, pending_cycle_request_n_n});
		for (i = 0; i < 4; i++) begin
			apb(1'h0, 8'(4 * i), 32'h0);
			chk("reg reset", i == 1 ? 32'h4 : 32'h0, rd);
		end
		apb(1'h0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, err);
		apb(1'h0, mxb_pkg::OFF_STAT, 32'h0);
		chk("source", 32'h0, rd[mxb_pkg::STAT_SRC_BIT]);
		$display("test reset done");
		// all width bit and pin combinations
		for (i = 0; i < 8; i++) begin
			wpin <= i[0];
			apb(1'h1, mxb_pkg::OFF_CFG0, 32'(i[2]) << mxb_pkg::CFG0_W16_BIT);
			apb(1'h1, mxb_pkg::OFF_CFG1, 32'(i[1]) << mxb_pkg::CFG1_W8_BIT);
			apb(1'h0, mxb_pkg::OFF_STAT, 32'h0);
			chk("width", i[2] && (!i[1] || i[0]), rd[mxb_pkg::STAT_W16_BIT]);
		end
		$display("test width done");
		// random traffic in every bus mode
		for (m = 0; m < 5; m++) begin
			wpin <= m == 3;
			bus16 <= mc0[m][1] && (!mc1[m][2] || m == 3);
			hbe <= mc0[m][2];
			apb(1'h1, mxb_pkg::OFF_CFG0, 32'(mc0[m]));
			apb(1'h1, mxb_pkg::OFF_CFG1, 32'(mc1[m]));
			q.delete();
			repeat (6) begin
				r = $urandom;
				q.push_back({r[16], r[31:16]});
				xfer(1'h1, r[16], r[17], r[31:16], r[16] ? r[15:0] : {r[7:0], r[7:0]});
			end
			foreach (q[i])
				xfer(1'h0, q[i][16], 1'h0, q[i][15:0], 16'h0);
		end
		$display("test traffic done");
		// takeover with a pending cycle
		apb(1'h1, mxb_pkg::OFF_WSEL, 32'h80);
		hold_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("grant", 32'h0, grant_n);
		apb(1'h0, mxb_pkg::OFF_STAT, 32'h0);
		chk("hold status", 32'h1 << mxb_pkg::STAT_HOLD_BIT, rd[4:0]);
		fork
			xfer(1'h0, 1'h1, 1'h0, 16'h0010, 16'h0);
			begin
				repeat (4) @(posedge sys_clk);
				chk("request", 32'h0, pending_cycle_request_n_n);
				hold_n <= 1'h1;
				repeat (2) @(posedge sys_clk);
				chk("request kept", 32'h0, pending_cycle_request_n_n);
				@(posedge sys_clk);
				#1;
				chk("released", 32'h3, {grant_n, pending_cycle_request_n_n});
			end
		join
		apb(1'h1, mxb_pkg::OFF_WSEL, 32'h0);
		hold_n <= 1'h0;
		xfer(1'h0, 1'h1, 1'h0, 16'h0020, 16'h0);
		chk("hold ignored", 32'h3, {grant_n, pending_cycle_request_n_n});
		hold_n <= 1'h1;
		$display("test takeover done");
		for (i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			c0 = clk_out;
			if (i > 0)
				chk("clock out", !c1, c0);
			c1 = c0;
		end
		// clock enable low freezes the divider along with everything else
		ce <= 1'h0;
		repeat (2) @(posedge sys_clk);
		c0 = clk_out;
		repeat (3) @(posedge sys_clk);
		chk("clock frozen", c0, clk_out);
		ce <= 1'h1;
		// ports stay with the bus while program runs outside
		apb(1'h1, mxb_pkg::OFF_GPIO, 32'hFFFF_A55A);
		@(posedge sys_clk);
		chk("ports kept", 32'h0, pins.ad_oe);
		do_reset(1'h1);
		src_int = 1'h1;
		bus16 <= 1'h0;
		hbe <= 1'h0;
		apb(1'h0, mxb_pkg::OFF_STAT, 32'h0);
		chk("source", 32'h1, rd[mxb_pkg::STAT_SRC_BIT]);
		apb(1'h1, mxb_pkg::OFF_GPIO, 32'hFFFF_A55A);
		@(posedge sys_clk);
		chk("gpio", 32'hFFFF_A55A, {pins.ad_oe, pins.ad_out});
		apb(1'h0, mxb_pkg::OFF_STAT, 32'h0);
		chk("line status", 32'h0000_A55A, rd[31:16]);
		xfer(1'h0, 1'h1, 1'h1, 16'h0100, 16'h0);
		xfer(1'h0, 1'h1, 1'h0, 16'h0100, 16'h0);
		$display("test source done");
		print_verdict();
	end
endmodule
